// ===== logic/iep_regs.vh
// Purpose: Offsets, field layouts, reset values and masks for the
//          interrupt enable and priority register block.
// Assumes: APB with 32-bit data; each register takes one aligned word.
// Notes:   Only the low 16 bits of each word are implemented.
`ifndef IEP_REGS_VH
`define IEP_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define IEP_OFS_EN0 8'h00
`define IEP_OFS_EN1 8'h04
`define IEP_OFS_EN3 8'h08
`define IEP_OFS_EN4 8'h0C
`define IEP_OFS_PRI0 8'h10
`define IEP_OFS_PRI1 8'h14
`define IEP_OFS_PRI2 8'h18
`define IEP_OFS_FLG0 8'h20
`define IEP_OFS_FLG1 8'h24
`define IEP_OFS_FLG3 8'h28
`define IEP_OFS_FLG4 8'h2C

// ****************************************************************
// Implemented bit masks (enable and flag registers share a layout)
// ****************************************************************
`define IEP_MASK_EN0 16'h3FEF
`define IEP_MASK_EN1 16'h20DB
`define IEP_MASK_EN3 16'h8600
`define IEP_MASK_EN4 16'h0602
`define IEP_MASK_PRI0 16'h7777
`define IEP_MASK_PRI1 16'h7770
`define IEP_MASK_PRI2 16'h7777

// ****************************************************************
// Reset values
// ****************************************************************
`define IEP_RST_EN 16'h0000
`define IEP_RST_PRI0 16'h4444
`define IEP_RST_PRI1 16'h4440
`define IEP_RST_PRI2 16'h4444
`define IEP_PRI_DEFAULT 3'h4
`define IEP_PRI_OFF 3'h0

// ****************************************************************
// Enable bit positions named in the first four enable registers
// ****************************************************************
`define IEP_BIT_EXT_PIN0 0
`define IEP_BIT_CAPTURE1 1
`define IEP_BIT_EXT_PIN2 13
`define IEP_BIT_CAPTURE8 7
`define IEP_BIT_CAPTURE7 6
`define IEP_BIT_EXT_PIN1 4
`define IEP_BIT_CHANGE_NOTIFY 3
`define IEP_BIT_I2C_MASTER 1
`define IEP_BIT_I2C_SLAVE 0
`define IEP_BIT_PWM_A_FAULT 15
`define IEP_BIT_ENCODER 10
`define IEP_BIT_PWM_A 9
`define IEP_BIT_PWM_B_FAULT 10
`define IEP_BIT_PWM_B 9
`define IEP_BIT_UART_ERROR 1

// ****************************************************************
// Priority field low bit positions
// ****************************************************************
`define IEP_FLD_HI 12
`define IEP_FLD_MH 8
`define IEP_FLD_ML 4
`define IEP_FLD_LO 0

`endif

// ===== logic/iep_src.v
// Purpose: One interrupt source slot: sticky flag and gated request.
// Assumes: Event and clear come from logic on sys_clk.
// Notes:   Unimplemented slots keep the flag at zero.
`timescale 1ns/1ps
`default_nettype none

module iep_src #(
  parameter IMPL = 1
) (
  input wire sys_clk, // System clock
  input wire nrst, // Synchronous reset, active low
  input wire event_in, // Source raised a request this cycle
  input wire clr, // Software write-one-to-clear
  input wire en, // Enable bit for this source
  input wire [2:0] prio, // Priority field for this source
  output reg flag_q, // Sticky flag
  output wire req // Gated request
);

  // ****************************************************************
  // Sticky flag; an event in the clear cycle still sets it
  // ****************************************************************
  always @(posedge sys_clk) begin
    if (!nrst || IMPL == 0) begin
      flag_q <= 1'b0;
    end else if (event_in) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end

  // Request only with flag, enable and a non-zero priority
  assign req = flag_q & en & (prio != 3'h0);

endmodule // iep_src

`default_nettype wire

// ===== logic/iep_top.v
// Purpose: Interrupt enable and priority registers with request gating.
// Assumes: APB3 slave, one wait state; sources pulse src_event on sys_clk.
// Notes:   Slot n = register*16 + bit, registers ordered en0, en1, en3, en4.
//
// Notes on behaviour
// - Enable one passes request, zero blocks it
// - Priority three bits; all ones is level seven
// - Code one is lowest level; codes linear
// - Priority zero disables source regardless of enable
// - Unimplemented bits read zero, ignore writes
// - Reset clears every enable bit
// - Reset loads every priority field with four
// - Enable bits read back last written value
// - First enable: capture1 bit1, ext pin0 bit0
// - Second enable register bit layout as listed
// - Third enable: fault A 15, encoder 10, pwm 9
// - First priority register field layout
// - Second priority register layout, low nibble unused
// - Third priority register field layout
// - Flag reads one after source raises request
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "iep_regs.vh"

module iep_top #(
  parameter ADDR_W = 8
) (
  input wire sys_clk, // System clock, 100 MHz
  input wire nrst, // Synchronous reset, active low
  input wire [ADDR_W-1:0] paddr, // APB byte address
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction, high for write
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error on unmapped address
  input wire [63:0] src_event, // One-cycle request pulses per slot
  output reg [63:0] irq_req, // Gated request per slot
  output reg [191:0] irq_level, // Priority level per slot, 3 bits each
  output reg irq_out // Any unmasked request pending
);

  // ****************************************************************
  // Local state
  // ****************************************************************
  reg [15:0] en0_q;
  reg [15:0] en1_q;
  reg [15:0] en3_q;
  reg [15:0] en4_q;
  reg [15:0] pri0_q;
  reg [15:0] pri1_q;
  reg [15:0] pri2_q;
  wire [63:0] flag_w;
  wire [63:0] req_w;
  wire [63:0] en_vec;
  wire [63:0] impl_vec;
  reg [63:0] clr_vec;
  reg [191:0] level_vec;
  wire access;
  wire wr_fire;
  wire rd_fire;
  reg [31:0] rdata_d;
  reg hit_d;
  // Named enable bits and priority fields
  wire ext_pin0_irq_en;
  wire capture1_irq_en;
  wire ext_pin2_irq_en;
  wire capture8_irq_en;
  wire capture7_irq_en;
  wire ext_pin1_irq_en;
  wire change_notify_irq_en;
  wire i2c_master_irq_en;
  wire i2c_slave_irq_en;
  wire pwm_a_fault_irq_en;
  wire encoder_irq_en;
  wire pwm_a_irq_en;
  wire pwm_b_fault_irq_en;
  wire pwm_b_irq_en;
  wire uart_error_irq_en;
  wire [2:0] ext_pin0_priority;
  wire [2:0] capture1_priority;
  wire [2:0] compare1_priority;
  wire [2:0] timer_a_priority;
  wire [2:0] capture2_priority;
  wire [2:0] compare2_priority;
  wire [2:0] timer_b_priority;
  wire [2:0] timer_c_priority;
  wire [2:0] spi_error_priority;
  wire [2:0] spi_event_priority;
  wire [2:0] uart_receive_priority;
  reg [15:0] gate0;
  reg [15:0] gate1;
  reg [15:0] gate3;
  reg [15:0] gate4;
  reg [15:0] pfld0;
  reg [15:0] pfld1;
  reg [15:0] pfld2;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Priority of a slot; slots without a field here use the reset level
  function [2:0] prio_of;
    input [5:0] slot;
    input [15:0] p0;
    input [15:0] p1;
    input [15:0] p2;
    begin
      case (slot)
        6'h00: prio_of = p0[`IEP_FLD_LO+2:`IEP_FLD_LO];
        6'h01: prio_of = p0[`IEP_FLD_ML+2:`IEP_FLD_ML];
        6'h02: prio_of = p0[`IEP_FLD_MH+2:`IEP_FLD_MH];
        6'h03: prio_of = p0[`IEP_FLD_HI+2:`IEP_FLD_HI];
        6'h05: prio_of = p1[`IEP_FLD_ML+2:`IEP_FLD_ML];
        6'h06: prio_of = p1[`IEP_FLD_MH+2:`IEP_FLD_MH];
        6'h07: prio_of = p1[`IEP_FLD_HI+2:`IEP_FLD_HI];
        6'h08: prio_of = p2[`IEP_FLD_LO+2:`IEP_FLD_LO];
        6'h09: prio_of = p2[`IEP_FLD_ML+2:`IEP_FLD_ML];
        6'h0A: prio_of = p2[`IEP_FLD_MH+2:`IEP_FLD_MH];
        6'h0B: prio_of = p2[`IEP_FLD_HI+2:`IEP_FLD_HI];
        default: prio_of = `IEP_PRI_DEFAULT;
      endcase
    end
  endfunction

  // Write data confined to implemented bits
  function [15:0] masked;
    input [31:0] data;
    input [15:0] mask;
    begin
      masked = data[15:0] & mask;
    end
  endfunction

  // ****************************************************************
  // APB handshake
  // ****************************************************************
  // One wait state keeps pready and prdata straight from flops
  assign access = psel & penable;
  assign wr_fire = access & pready & pwrite;
  assign rd_fire = access & ~pready & ~pwrite;

  always @(posedge sys_clk) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access & ~pready;
      pslverr <= access & ~pready & ~hit_d;
      if (rd_fire) begin
        prdata <= rdata_d;
      end else if (!access) begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ****************************************************************
  // Address decode and read mux
  // ****************************************************************
  always @* begin
    hit_d = 1'b1;
    rdata_d = 32'h00000000;
    case (paddr)
      `IEP_OFS_EN0: rdata_d[15:0] = en0_q;
      `IEP_OFS_EN1: rdata_d[15:0] = en1_q;
      `IEP_OFS_EN3: rdata_d[15:0] = en3_q;
      `IEP_OFS_EN4: rdata_d[15:0] = en4_q;
      `IEP_OFS_PRI0: rdata_d[15:0] = pri0_q;
      `IEP_OFS_PRI1: rdata_d[15:0] = pri1_q;
      `IEP_OFS_PRI2: rdata_d[15:0] = pri2_q;
      `IEP_OFS_FLG0: rdata_d[15:0] = flag_w[15:0];
      `IEP_OFS_FLG1: rdata_d[15:0] = flag_w[31:16];
      `IEP_OFS_FLG3: rdata_d[15:0] = flag_w[47:32];
      `IEP_OFS_FLG4: rdata_d[15:0] = flag_w[63:48];
      default: hit_d = 1'b0;
    endcase
  end

  // ****************************************************************
  // Enable and priority registers
  // ****************************************************************
  // Stored value is always masked, so unused bits stay zero
  always @(posedge sys_clk) begin
    if (!nrst) begin
      en0_q <= `IEP_RST_EN;
      en1_q <= `IEP_RST_EN;
      en3_q <= `IEP_RST_EN;
      en4_q <= `IEP_RST_EN;
      pri0_q <= `IEP_RST_PRI0 & `IEP_MASK_PRI0;
      pri1_q <= `IEP_RST_PRI1 & `IEP_MASK_PRI1;
      pri2_q <= `IEP_RST_PRI2 & `IEP_MASK_PRI2;
    end else if (wr_fire) begin
      case (paddr)
        `IEP_OFS_EN0: en0_q <= masked(pwdata, `IEP_MASK_EN0);
        `IEP_OFS_EN1: en1_q <= masked(pwdata, `IEP_MASK_EN1);
        `IEP_OFS_EN3: en3_q <= masked(pwdata, `IEP_MASK_EN3);
        `IEP_OFS_EN4: en4_q <= masked(pwdata, `IEP_MASK_EN4);
        `IEP_OFS_PRI0: pri0_q <= masked(pwdata, `IEP_MASK_PRI0);
        `IEP_OFS_PRI1: pri1_q <= masked(pwdata, `IEP_MASK_PRI1);
        `IEP_OFS_PRI2: pri2_q <= masked(pwdata, `IEP_MASK_PRI2);
        default: en0_q <= en0_q;
      endcase
    end
  end

  // ****************************************************************
  // Flag clear strobes, write one to clear
  // ****************************************************************
  always @* begin
    clr_vec = 64'h0000000000000000;
    if (wr_fire) begin
      case (paddr)
        `IEP_OFS_FLG0: clr_vec[15:0] = pwdata[15:0];
        `IEP_OFS_FLG1: clr_vec[31:16] = pwdata[15:0];
        `IEP_OFS_FLG3: clr_vec[47:32] = pwdata[15:0];
        `IEP_OFS_FLG4: clr_vec[63:48] = pwdata[15:0];
        default: clr_vec = 64'h0000000000000000;
      endcase
    end
  end

  // ****************************************************************
  // Per-slot gating
  // ****************************************************************
  assign en_vec = {gate4, gate3, gate1, gate0};
  assign impl_vec = {`IEP_MASK_EN4, `IEP_MASK_EN3, `IEP_MASK_EN1, `IEP_MASK_EN0};

  // ****************************************************************
  // Named enable bits
  // ****************************************************************
  // Bit layout lives here once; gating below uses these names, but gate0 starts from all of en0_q
  assign ext_pin0_irq_en = en0_q[`IEP_BIT_EXT_PIN0];
  assign capture1_irq_en = en0_q[`IEP_BIT_CAPTURE1];
  assign ext_pin2_irq_en = en1_q[`IEP_BIT_EXT_PIN2];
  assign capture8_irq_en = en1_q[`IEP_BIT_CAPTURE8];
  assign capture7_irq_en = en1_q[`IEP_BIT_CAPTURE7];
  assign ext_pin1_irq_en = en1_q[`IEP_BIT_EXT_PIN1];
  assign change_notify_irq_en = en1_q[`IEP_BIT_CHANGE_NOTIFY];
  assign i2c_master_irq_en = en1_q[`IEP_BIT_I2C_MASTER];
  assign i2c_slave_irq_en = en1_q[`IEP_BIT_I2C_SLAVE];
  assign pwm_a_fault_irq_en = en3_q[`IEP_BIT_PWM_A_FAULT];
  assign encoder_irq_en = en3_q[`IEP_BIT_ENCODER];
  assign pwm_a_irq_en = en3_q[`IEP_BIT_PWM_A];
  assign pwm_b_fault_irq_en = en4_q[`IEP_BIT_PWM_B_FAULT];
  assign pwm_b_irq_en = en4_q[`IEP_BIT_PWM_B];
  assign uart_error_irq_en = en4_q[`IEP_BIT_UART_ERROR];

  // ****************************************************************
  // Named priority fields
  // ****************************************************************
  // Three bits each; bit 3 of every nibble is never stored
  assign ext_pin0_priority = pri0_q[`IEP_FLD_LO+2:`IEP_FLD_LO];
  assign capture1_priority = pri0_q[`IEP_FLD_ML+2:`IEP_FLD_ML];
  assign compare1_priority = pri0_q[`IEP_FLD_MH+2:`IEP_FLD_MH];
  assign timer_a_priority = pri0_q[`IEP_FLD_HI+2:`IEP_FLD_HI];
  assign capture2_priority = pri1_q[`IEP_FLD_ML+2:`IEP_FLD_ML];
  assign compare2_priority = pri1_q[`IEP_FLD_MH+2:`IEP_FLD_MH];
  assign timer_b_priority = pri1_q[`IEP_FLD_HI+2:`IEP_FLD_HI];
  assign timer_c_priority = pri2_q[`IEP_FLD_LO+2:`IEP_FLD_LO];
  assign spi_error_priority = pri2_q[`IEP_FLD_ML+2:`IEP_FLD_ML];
  assign spi_event_priority = pri2_q[`IEP_FLD_MH+2:`IEP_FLD_MH];
  assign uart_receive_priority = pri2_q[`IEP_FLD_HI+2:`IEP_FLD_HI];

  // Gate words rebuilt from names; unnamed positions stay zero except in gate0, which starts from en0_q
  always @* begin
    gate0 = en0_q;
    gate1 = 16'h0000;
    gate3 = 16'h0000;
    gate4 = 16'h0000;
    gate0[`IEP_BIT_EXT_PIN0] = ext_pin0_irq_en;
    gate0[`IEP_BIT_CAPTURE1] = capture1_irq_en;
    gate1[`IEP_BIT_EXT_PIN2] = ext_pin2_irq_en;
    gate1[`IEP_BIT_CAPTURE8] = capture8_irq_en;
    gate1[`IEP_BIT_CAPTURE7] = capture7_irq_en;
    gate1[`IEP_BIT_EXT_PIN1] = ext_pin1_irq_en;
    gate1[`IEP_BIT_CHANGE_NOTIFY] = change_notify_irq_en;
    gate1[`IEP_BIT_I2C_MASTER] = i2c_master_irq_en;
    gate1[`IEP_BIT_I2C_SLAVE] = i2c_slave_irq_en;
    gate3[`IEP_BIT_PWM_A_FAULT] = pwm_a_fault_irq_en;
    gate3[`IEP_BIT_ENCODER] = encoder_irq_en;
    gate3[`IEP_BIT_PWM_A] = pwm_a_irq_en;
    gate4[`IEP_BIT_PWM_B_FAULT] = pwm_b_fault_irq_en;
    gate4[`IEP_BIT_PWM_B] = pwm_b_irq_en;
    gate4[`IEP_BIT_UART_ERROR] = uart_error_irq_en;
    pfld0 = 16'h0000;
    pfld1 = 16'h0000;
    pfld2 = 16'h0000;
    pfld0[`IEP_FLD_LO +: 3] = ext_pin0_priority;
    pfld0[`IEP_FLD_ML +: 3] = capture1_priority;
    pfld0[`IEP_FLD_MH +: 3] = compare1_priority;
    pfld0[`IEP_FLD_HI +: 3] = timer_a_priority;
    pfld1[`IEP_FLD_ML +: 3] = capture2_priority;
    pfld1[`IEP_FLD_MH +: 3] = compare2_priority;
    pfld1[`IEP_FLD_HI +: 3] = timer_b_priority;
    pfld2[`IEP_FLD_LO +: 3] = timer_c_priority;
    pfld2[`IEP_FLD_ML +: 3] = spi_error_priority;
    pfld2[`IEP_FLD_MH +: 3] = spi_event_priority;
    pfld2[`IEP_FLD_HI +: 3] = uart_receive_priority;
  end

  // Level table; linear code to level mapping, zero means off
  always @* begin : lvl_blk
    integer i;
    i = 0;
    level_vec = 192'h0;
    for (i = 0; i < 64; i = i + 1) begin
      level_vec[3*i +: 3] = prio_of(i[5:0], pfld0, pfld1, pfld2);
    end
  end

  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1) begin : slot
      iep_src #(
        .IMPL(((64'h06028600_20DB3FEF >> g) & 64'h1) != 64'h0 ? 1 : 0)
      ) u_src (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .event_in(src_event[g] & impl_vec[g]),
        .clr(clr_vec[g]),
        .en(en_vec[g]),
        .prio(level_vec[3*g +: 3]),
        .flag_q(flag_w[g]),
        .req(req_w[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Registered request outputs
  // ****************************************************************
  // A write at edge N reaches these flops at edge N+1
  always @(posedge sys_clk) begin
    if (!nrst) begin
      irq_req <= 64'h0000000000000000;
      irq_level <= 192'h0;
      irq_out <= 1'b0;
    end else begin
      irq_req <= req_w;
      irq_level <= level_vec;
      irq_out <= |req_w;
    end
  end

endmodule // iep_top

`default_nettype wire

// ===== testbench/iep_src_model.sv
// Purpose: Peripheral source model that raises request pulses.
// Assumes: Pulses are launched just after a rising edge.
// Notes:   Each pulse lasts exactly one clock cycle.
`timescale 1ns/1ps
`default_nettype none

module iep_src_model (
  input wire logic sys_clk, // System clock
  output logic [63:0] src_event // Pulses toward the block
);
  // One-cycle pulse; a level here would refire after a clear
  task automatic pulse(input logic [63:0] v);
    src_event <= v;
    @(posedge sys_clk);
    src_event <= 64'h0;
  endtask

  // Quiet at start
  initial src_event = 64'h0;
endmodule // iep_src_model
`default_nettype wire

// ===== testbench/iep_top_properties.sv
// Purpose: Concurrent checks on the enable and priority block ports.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to the top module from the bench file.
`timescale 1ns/1ps
`default_nettype none
`include "iep_regs.vh"

module iep_top_properties (
  input wire logic sys_clk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Access phase
  input wire logic pwrite, // Direction
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [63:0] src_event, // Source pulses
  input wire logic [63:0] irq_req, // Requests
  input wire logic [191:0] irq_level, // Levels
  input wire logic irq_out // Summary
);
  logic wr_done;
  logic ev_any;
  logic lvl_bad;
  // Completed write and any source pulse
  assign wr_done = psel && penable && pready && pwrite;
  assign ev_any = |src_event;
  // A request with level zero should never exist
  always_comb begin
    lvl_bad = 1'b0;
    for (int n = 0; n < 64; n++) begin
      if (irq_req[n] && irq_level[3*n +: 3] == 3'h0) begin
        lvl_bad = 1'b1;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_upper_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  out_or_a: assert property (irq_out == |irq_req)
    else $error("irq_out differs from requests");
  zero_level_a: assert property (!lvl_bad)
    else $error("request at level zero");
  unimpl_slot_a: assert property ((irq_req & ~{`IEP_MASK_EN4, `IEP_MASK_EN3,
    `IEP_MASK_EN1, `IEP_MASK_EN0}) == 64'h0)
    else $error("request on unimplemented slot");
  reset_state_a: assert property ($rose(nrst) |=> irq_req == 64'h0
    && irq_level == {64{3'h4}}) else $error("bad state after reset");
  req_rise_a: assert property (|(irq_req & ~$past(irq_req)) |->
    $past(ev_any, 2) || $past(wr_done) || $past(wr_done, 2)) else $error("request rose unasked");
  req_fall_a: assert property (|($past(irq_req) & ~irq_req) |->
    $past(wr_done) || $past(wr_done, 2)) else $error("request fell unasked");
endmodule // iep_top_properties
`default_nettype wire

// ===== testbench/iep_top_tb.sv
// Purpose: Self-checking bench for the enable and priority block.
// Assumes: APB master drives by non-blocking assignment after edges.
// Notes:   A bench model of enables, priorities and flags predicts all.
`timescale 1ns/1ps
`default_nettype none
`include "iep_regs.vh"

module iep_top_tb;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, d;
  logic pready, pslverr, irq_out, er;
  logic [63:0] src_event, irq_req, v;
  logic [191:0] irq_level, lv;
  logic [15:0] m [7];
  logic [15:0] fl [4];
  logic [15:0] mk [7] = '{`IEP_MASK_EN0, `IEP_MASK_EN1, `IEP_MASK_EN3, `IEP_MASK_EN4,
    `IEP_MASK_PRI0, `IEP_MASK_PRI1, `IEP_MASK_PRI2};
  int num_errors = 0;
  int checks = 0;

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  iep_top uut (.sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_event(src_event), .irq_req(irq_req),
    .irq_level(irq_level), .irq_out(irq_out));
  iep_src_model src (.sys_clk(sys_clk), .src_event(src_event));

  // Compare and count
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Model of level table; slot 4 and slots past 11 sit at level four
  function automatic logic [191:0] elvl();
    logic [191:0] q;
    for (int n = 0; n < 64; n++) begin
      q[3*n +: 3] = 3'h4;
      if (n < 12 && n != 4) q[3*n +: 3] = 3'(m[4 + n/4] >> (4*(n%4)));
    end
    return q;
  endfunction

  // Model of gated requests; slots past 11 sit at level four
  function automatic logic [63:0] ereq();
    logic [63:0] r;
    logic [2:0] l;
    for (int n = 0; n < 64; n++) begin
      l = 3'h4;
      if (n < 12) l = 3'(m[4 + n/4] >> (4*(n%4)));
      r[n] = fl[n/16][n%16] & m[n/16][n%16] & (l != 3'h0);
    end
    return r;
  endfunction

  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, far beyond the expected run
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h7C80));
    m = '{16'h0, 16'h0, 16'h0, 16'h0, `IEP_RST_PRI0, `IEP_RST_PRI1, `IEP_RST_PRI2};
    fl = '{default: 16'h0};
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    // Reset values, then an unmapped write
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4*i), 32'h0);
      chk(rd, {16'h0, m[i]});
    end
    apb(1'b1, 8'h30, 32'hFFFFFFFF);
    chk(er, 1'b1);
    // Random writes read back through the implemented masks
    for (int i = 0; i < 7; i++) begin
      d = $urandom;
      apb(1'b1, 8'(4*i), d);
      m[i] = d[15:0] & mk[i];
    end
    apb(1'b0, 8'h30, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4*i), 32'h0);
      chk(rd, {16'h0, m[i]});
    end
    // Every priority code with random enables, events and clears
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 7; i++) begin
        d = (i < 4) ? $urandom : k * 32'h1111;
        apb(1'b1, 8'(4*i), d);
        m[i] = d[15:0] & mk[i];
      end
      v = {$urandom, $urandom};
      src.pulse(v);
      for (int j = 0; j < 4; j++) fl[j] |= v[16*j +: 16] & mk[j];
      repeat (3) @(posedge sys_clk);
      #1;
      chk(irq_req, ereq());
      chk(irq_out, |ereq());
      chk({irq_level[35:33], irq_level[17:15], irq_level[2:0]}, {3{k[2:0]}});
      lv = elvl();
      for (int j = 0; j < 3; j++) chk(irq_level[64*j +: 64], lv[64*j +: 64]);
      for (int j = 0; j < 4; j++) begin
        apb(1'b0, 8'h20 + 8'(4*j), 32'h0);
        chk(rd, {16'h0, fl[j]});
      end
      for (int j = 0; j < 4; j++) begin
        d = $urandom;
        apb(1'b1, 8'h20 + 8'(4*j), d);
        fl[j] &= ~d[15:0];
      end
      repeat (2) @(posedge sys_clk);
      #1;
      chk(irq_req, ereq());
    end
    tally_and_finish();
  end
endmodule // iep_top_tb

bind iep_top iep_top_properties chk_i (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .src_event(src_event), .irq_req(irq_req),
  .irq_level(irq_level), .irq_out(irq_out));
`default_nettype wire
